/* File: hdl/pwmmc_pkg.sv */
// package: register map, field layouts and reset values of the pwm master
`default_nettype none
package pwmmc_pkg;
    // number of pwm outputs and counter width
    localparam int PWMMC_NUM_OUT = 6;
    localparam int PWMMC_CNT_W = 12;
    localparam int PWMMC_ADDR_W = 12;
    // register byte addresses
    localparam logic [11:0] PWMMC_CTL0_ADDR = 12'hf20;
    localparam logic [11:0] PWMMC_CTL1_ADDR = 12'hf24;
    localparam logic [11:0] PWMMC_MASK_ADDR = 12'hf28;
    localparam logic [11:0] PWMMC_OFFLVL_ADDR = 12'hf2c;
    localparam logic [11:0] PWMMC_PERIOD_ADDR = 12'hf30;
    localparam logic [11:0] PWMMC_STATUS_ADDR = 12'hf34;
    localparam logic [11:0] PWMMC_DUTY_BASE = 12'hf40;
    // status field positions
    localparam int PWMMC_STAT_CTRL_BIT = 16;
    localparam int PWMMC_STAT_DOWN_BIT = 17;
    // reset values
    localparam logic [7:0] PWMMC_CTL0_RST = 8'h00;
    localparam logic [7:0] PWMMC_CTL1_RST = 8'h00;
    localparam logic [11:0] PWMMC_PERIOD_RST = 12'h0ff;
    localparam logic [11:0] PWMMC_DUTY_RST = 12'h000;
    // master control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic outputs_off_control;
        logic selective_output_disable;
        logic align_center;
        logic rsvd4;
        logic converter_trigger_enable;
        logic rsvd2;
        logic ready;
        logic modulator_enable;
    } pwmmc_ctl0_t;
    // second control register: reload interval and prescale holds
    typedef struct packed {
        logic [1:0] reload_interval;
        logic [3:0] rsvd;
        logic [1:0] prescale;
    } pwmmc_ctl1_t;
    // working timebase values shared by top and counter
    typedef struct packed {
        logic [PWMMC_CNT_W-1:0] period;
        logic [1:0] prescale;
    } pwmmc_work_t;
endpackage
`default_nettype wire

/* File: hdl/pwmmc_counter.sv */
// master pwm counter with prescaler, edge and center alignment
`default_nettype none
module pwmmc_counter
    import pwmmc_pkg::*;
#(
    parameter int CNT_W = PWMMC_CNT_W
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic center,
    input wire logic [1:0] prescale,
    input wire logic [CNT_W-1:0] period,
    output logic [CNT_W-1:0] count,
    output logic down,
    output logic period_end
);
    // counter state
    typedef struct packed {
        logic [2:0] div;
        logic [CNT_W-1:0] count;
        logic down;
        logic period_end;
    } pwmmc_cnt_state_t;

    pwmmc_cnt_state_t st_ff; // registered state
    pwmmc_cnt_state_t nxt_st; // next state
    logic [2:0] div_max; // last prescaler count
    logic tick; // one counter step

    assign div_max = 3'((4'h1 << prescale) - 4'h1);
    assign tick = run && (st_ff.div == div_max);

    // next state of prescaler and counter
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.period_end = 1'b0;
        if (!run)
        begin
            // stopped and cleared while disabled
            nxt_st = '0;
        end
        else if (!tick)
        begin
            nxt_st.div = st_ff.div + 3'h1;
        end
        else
        begin
            nxt_st.div = 3'h0;
            if (!center)
            begin
                // edge aligned ramp 0..period
                if (st_ff.count >= period)
                begin
                    nxt_st.count = '0;
                    nxt_st.period_end = 1'b1;
                end
                else
                    nxt_st.count = st_ff.count + 1'b1;
            end
            else if (!st_ff.down)
            begin
                // center aligned up slope
                if (st_ff.count >= period)
                begin
                    nxt_st.down = 1'b1;
                    if (st_ff.count != '0)
                        nxt_st.count = st_ff.count - 1'b1;
                end
                else
                    nxt_st.count = st_ff.count + 1'b1;
            end
            else
            begin
                // down slope ends the period at zero
                if (st_ff.count == '0)
                begin
                    nxt_st.down = 1'b0;
                    nxt_st.period_end = 1'b1;
                end
                else
                    nxt_st.count = st_ff.count - 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign count = st_ff.count;
    assign down = st_ff.down;
    assign period_end = st_ff.period_end;

    // two stopped cycles leave the counter at zero
    sequence stopped_s;
        !run [*2];
    endsequence
    // edge aligned wrap at the period value
    sequence edge_wrap_s;
        tick && !center && (st_ff.count >= period);
    endsequence

    counter_stop_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        stopped_s |-> (st_ff.count == '0) && !st_ff.down)
        else $error("counter not held while disabled");
    edge_wrap_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        edge_wrap_s |=> (st_ff.count == '0) && st_ff.period_end)
        else $error("edge aligned counter did not wrap");
    center_turn_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_ff.period_end && $past(center) && $past(run))
            |-> $past(st_ff.down) && !st_ff.down)
        else $error("center period did not end on down slope");
endmodule
`default_nettype wire

/* File: hdl/pwmmc_outstage.sv */
// per output compare and off-state forcing
`default_nettype none
module pwmmc_outstage
    import pwmmc_pkg::*;
#(
    parameter int N = PWMMC_NUM_OUT,
    parameter int CNT_W = PWMMC_CNT_W
)
(
    input wire logic [CNT_W-1:0] count,
    input wire logic [N-1:0][CNT_W-1:0] duty,
    input wire logic run,
    input wire logic control,
    input wire logic sel_disable,
    input wire logic [N-1:0] mask,
    input wire logic [N-1:0] off_level,
    output logic [N-1:0] raw,
    output logic [N-1:0] pin_next
);
    // one compare and gate per output
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_out
            // active while count below duty
            assign raw[i] = (count < duty[i]);
            // off-state when stopped, outputs off or masked
            assign pin_next[i] = (!run || !control ||
                                  (sel_disable && mask[i]))
                                 ? off_level[i] : raw[i];
        end
    endgenerate
endmodule
`default_nettype wire

/* File: hdl/pwmmc_top.sv */
// pwm master control: apb registers, reload handshake and pin gating
//
// Operation
// - outputs off bit low forces off-state immediately
// - outputs off bit high returns control at reload
// - selective disable low: modulator drives all outputs
// - selective disable high: masked outputs forced off
// - alignment bit low gives edge aligned waveforms
// - alignment bit high gives center aligned waveforms
// - converter trigger pulses only when enable bit set
// - ready high: copy holding values at reload
// - modulator disabled forces outputs to off-state
// - disabled modulator holds master counter stopped
// - enabled modulator drives the pins
// - reload every period, or every 2/4/8
`default_nettype none
module pwmmc_top
    import pwmmc_pkg::*;
#(
    parameter int N = PWMMC_NUM_OUT,
    parameter int CNT_W = PWMMC_CNT_W
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PWMMC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [N-1:0] pwm_out,
    output logic adc_trigger
);
    // whole block state
    typedef struct packed {
        pwmmc_ctl0_t ctl0;
        pwmmc_ctl1_t ctl1;
        logic [N-1:0] mask;
        logic [N-1:0] off_level;
        logic [CNT_W-1:0] period_hold;
        logic [N-1:0][CNT_W-1:0] duty_hold;
        logic [N-1:0][CNT_W-1:0] duty_work;
        pwmmc_work_t work;
        logic [1:0] interval;
        logic [2:0] reload_cnt;
        logic modulator_control;
        logic [N-1:0] pins;
        logic adc_trigger;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pwmmc_top_state_t;

    pwmmc_top_state_t st_ff; // registered state
    pwmmc_top_state_t nxt_st; // next state

    logic [CNT_W-1:0] count; // master counter value
    logic cnt_down; // center aligned down slope
    logic period_end; // one pulse per pwm period
    logic [2:0] interval_max; // periods per reload minus one
    logic reload; // reload event this cycle
    logic [N-1:0] raw; // unforced modulator outputs
    logic [N-1:0] pin_next; // gated outputs
    logic apb_take; // access completes this edge
    logic wr_take; // completed write
    logic duty_hit; // address inside duty block
    logic [2:0] duty_idx; // selected duty register
    logic [31:0] rd_data; // read mux
    logic rd_err; // unmapped address

    // master counter, stopped while disabled
    pwmmc_counter #(
        .CNT_W(CNT_W)
    ) u_counter (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .run(st_ff.ctl0.modulator_enable),
        .center(st_ff.ctl0.align_center),
        .prescale(st_ff.work.prescale),
        .period(st_ff.work.period),
        .count(count),
        .down(cnt_down),
        .period_end(period_end)
    );

    // compare and off-state gating per output
    pwmmc_outstage #(
        .N(N),
        .CNT_W(CNT_W)
    ) u_outstage (
        .count(count),
        .duty(st_ff.duty_work),
        .run(st_ff.ctl0.modulator_enable),
        .control(st_ff.modulator_control),
        .sel_disable(st_ff.ctl0.selective_output_disable),
        .mask(st_ff.mask),
        .off_level(st_ff.off_level),
        .raw(raw),
        .pin_next(pin_next)
    );

    // reload every 1, 2, 4 or 8 periods
    // a shorter new interval must not strand the count above its limit
    assign interval_max = 3'((4'h1 << st_ff.interval) - 4'h1);
    assign reload = period_end && st_ff.ctl0.modulator_enable &&
                    (st_ff.reload_cnt >= interval_max);

    // apb access phase ends when our registered ready is seen
    assign apb_take = psel && penable && st_ff.pready;
    assign wr_take = apb_take && pwrite;
    assign duty_idx = paddr[4:2];
    assign duty_hit = (paddr[11:5] == PWMMC_DUTY_BASE[11:5]) &&
                      (duty_idx < 3'(N));

    // read mux and address decode
    always_comb
    begin
        rd_data = 32'h0;
        rd_err = 1'b0;
        if (paddr[1:0] != 2'b00)
            rd_err = 1'b1; // unaligned
        else if (paddr == PWMMC_CTL0_ADDR)
            rd_data = 32'(st_ff.ctl0); // reserved bits read back
        else if (paddr == PWMMC_CTL1_ADDR)
            rd_data = 32'(st_ff.ctl1);
        else if (paddr == PWMMC_MASK_ADDR)
            rd_data = 32'(st_ff.mask);
        else if (paddr == PWMMC_OFFLVL_ADDR)
            rd_data = 32'(st_ff.off_level);
        else if (paddr == PWMMC_PERIOD_ADDR)
            rd_data = 32'(st_ff.period_hold);
        else if (paddr == PWMMC_STATUS_ADDR)
        begin
            // live counter and control state
            rd_data = 32'(count);
            rd_data[PWMMC_STAT_CTRL_BIT] = st_ff.modulator_control;
            rd_data[PWMMC_STAT_DOWN_BIT] = cnt_down;
        end
        else if (duty_hit)
            rd_data = 32'(st_ff.duty_hold[duty_idx]);
        else
            rd_err = 1'b1; // unmapped
    end

    // next state of the whole block
    always_comb
    begin
        nxt_st = st_ff;
        // apb answer: one wait cycle, then ready for one cycle
        nxt_st.pready = psel && penable && !st_ff.pready;
        if (psel && penable && !st_ff.pready)
        begin
            nxt_st.prdata = pwrite ? 32'h0 : rd_data;
            nxt_st.pslverr = rd_err;
        end
        else
        begin
            nxt_st.prdata = 32'h0;
            nxt_st.pslverr = 1'b0;
        end
        // reload interval counting, hardware side
        if (!st_ff.ctl0.modulator_enable)
            nxt_st.reload_cnt = 3'h0;
        else if (period_end)
        begin
            nxt_st.reload_cnt = reload ? 3'h0 : st_ff.reload_cnt + 3'h1;
            // interval hold takes effect at each period end
            nxt_st.interval = st_ff.ctl1.reload_interval;
        end
        // holding to working transfer only when ready
        if (reload && st_ff.ctl0.ready)
        begin
            // copy holding values and consume ready
            nxt_st.work.period = st_ff.period_hold;
            nxt_st.work.prescale = st_ff.ctl1.prescale;
            nxt_st.duty_work = st_ff.duty_hold;
            nxt_st.ctl0.ready = 1'b0;
        end
        // software writes after hardware updates, so a write wins
        if (wr_take && !rd_err)
        begin
            if (paddr == PWMMC_CTL0_ADDR)
                nxt_st.ctl0 = pwmmc_ctl0_t'(pwdata[7:0]);
            else if (paddr == PWMMC_CTL1_ADDR)
                nxt_st.ctl1 = pwmmc_ctl1_t'(pwdata[7:0]);
            else if (paddr == PWMMC_MASK_ADDR)
                nxt_st.mask = pwdata[N-1:0];
            else if (paddr == PWMMC_OFFLVL_ADDR &&
                     !st_ff.ctl0.modulator_enable)
                nxt_st.off_level = pwdata[N-1:0];
            else if (paddr == PWMMC_PERIOD_ADDR)
                nxt_st.period_hold = pwdata[CNT_W-1:0];
            else if (duty_hit)
                nxt_st.duty_hold[duty_idx] = pwdata[CNT_W-1:0];
        end
        // outputs off acts at once, return waits for reload
        if (!nxt_st.ctl0.outputs_off_control)
            nxt_st.modulator_control = 1'b0;
        else if (reload)
            nxt_st.modulator_control = 1'b1;
        // registered pins and converter trigger
        nxt_st.pins = pin_next;
        nxt_st.adc_trigger = period_end &&
                             st_ff.ctl0.modulator_enable &&
                             st_ff.ctl0.converter_trigger_enable;
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
            st_ff.ctl0 <= pwmmc_ctl0_t'(PWMMC_CTL0_RST);
            st_ff.ctl1 <= pwmmc_ctl1_t'(PWMMC_CTL1_RST);
            st_ff.period_hold <= CNT_W'(PWMMC_PERIOD_RST);
            st_ff.duty_hold <= {N{CNT_W'(PWMMC_DUTY_RST)}};
        end
        else
            st_ff <= nxt_st;
    end

    // outputs straight from flops
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign pwm_out = st_ff.pins;
    assign adc_trigger = st_ff.adc_trigger;

    // outputs off cleared means control dropped
    off_control_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !st_ff.ctl0.outputs_off_control |-> !st_ff.modulator_control)
        else $error("control kept while outputs off");
    off_pins_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !st_ff.modulator_control |=> pwm_out == $past(st_ff.off_level))
        else $error("pins not at off-state without control");
    return_reload_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        $rose(st_ff.modulator_control) |-> $past(reload))
        else $error("control returned outside reload");
    drive_all_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_ff.ctl0.modulator_enable && st_ff.modulator_control &&
         !st_ff.ctl0.selective_output_disable) |=> pwm_out == $past(raw))
        else $error("modulator not driving outputs");
    mask_force_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        st_ff.ctl0.selective_output_disable |=>
            ((pwm_out ^ $past(st_ff.off_level)) & $past(st_ff.mask)) == '0)
        else $error("masked output not forced off");
    trig_gate_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        st_ff.adc_trigger |-> $past(st_ff.ctl0.converter_trigger_enable)
            && $past(period_end))
        else $error("trigger without enable");
    hold_keep_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !st_ff.ctl0.ready |=> $stable(st_ff.work) &&
            $stable(st_ff.duty_work))
        else $error("working values changed without ready");
    transfer_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (reload && st_ff.ctl0.ready) |=>
            st_ff.work.period == $past(st_ff.period_hold) &&
            st_ff.duty_work == $past(st_ff.duty_hold))
        else $error("holding values not transferred");
    disabled_off_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !st_ff.ctl0.modulator_enable |=>
            pwm_out == $past(st_ff.off_level))
        else $error("outputs not off while disabled");
    lock_write_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_ff.ctl0.modulator_enable && wr_take &&
         paddr == PWMMC_OFFLVL_ADDR) |=> $stable(st_ff.off_level))
        else $error("locked register written while enabled");
    every_period_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (period_end && st_ff.ctl0.modulator_enable &&
         st_ff.interval == 2'b00) |-> reload)
        else $error("reload missed at period end");
    rsvd_back_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr_take && paddr == PWMMC_CTL0_ADDR) |=>
            st_ff.ctl0.rsvd4 == $past(pwdata[4]) &&
            st_ff.ctl0.rsvd2 == $past(pwdata[2]))
        else $error("reserved bits not stored");
endmodule
`default_nettype wire

/* File: tb/pwmmc_stage_model.sv */
// power stage model: counts gate on-time per pin and converter triggers
`default_nettype none
module pwmmc_stage_model
(
    input wire logic core_clk,
    input wire logic clr,
    input wire logic [5:0] pwm_out,
    input wire logic adc_trigger,
    output var int hi_cnt [6],
    output var int trig_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    // gate drives sampled once per cycle, cleared on request
    always @(posedge core_clk)
    begin
        for (int i = 0; i < 6; i++)
            hi_cnt[i] <= clr ? 0 : hi_cnt[i] + int'(pwm_out[i]);
        trig_cnt <= clr ? 0 : trig_cnt + int'(adc_trigger);
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// testbench: apb driven checks of the pwm master control block
`default_nettype none
module tb
    import pwmmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int P = 7; // working period, ticks per period are p+1
    localparam int W = 64; // measuring window in clock cycles, a whole number of periods
    logic core_clk = 0;
    logic reset_n = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic adc_trigger;
    logic [5:0] pwm_out;
    logic clr = 1; // clears the stage model counters
    int hi_cnt [6];
    int trig_cnt;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int duty_h [6]; // model of the holding duties
    int duty_w [6]; // model of the working duties
    logic [31:0] rd;
    logic er;
    logic [5:0] offl = 6'h2a; // off-state levels
    logic [5:0] mask = 6'h03; // per output disable bits
    // free running system clock
    always #10 core_clk = ~core_clk;
    pwmmc_top pwmmc_top_inst (.core_clk(core_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_out(pwm_out), .adc_trigger(adc_trigger));
    pwmmc_stage_model pwmmc_stage_model_inst (.core_clk(core_clk),
        .clr(clr), .pwm_out(pwm_out), .adc_trigger(adc_trigger),
        .hi_cnt(hi_cnt), .trig_cnt(trig_cnt));
    // verdict and end of run
    task test_done();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // register value comparison
    task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    // pin level or pin count comparison
    task cmp_pin(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t pin got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        // pready and read data are taken as sampled by this very edge
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20)
            cmp_reg({31'h0, pready}, 32'h1);
        // the sampling edge commits, release the request right after it
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        cmp_reg(rd, exp);
    endtask
    // poll a register bit until it reaches a level, bounded
    task wait_bit(input logic [11:0] a, input int b, input logic v);
        int n;
        n = 0;
        do
        begin
            apb(0, a, 32'h0);
            n++;
        end
        while (rd[b] !== v && n < 40);
        cmp_reg({31'h0, rd[b]}, {31'h0, v});
    endtask
    // random duties into the holding registers
    task load_duty();
        for (int i = 0; i < 6; i++)
        begin
            duty_h[i] = $urandom_range(P + 1, 0);
            wr(PWMMC_DUTY_BASE + 12'(4 * i), 32'(duty_h[i]));
        end
    endtask
    // on-time over a window against the model; forced pins sit off
    task measure(input logic [5:0] forced, input int trig);
        int e;
        repeat (4) @(posedge core_clk);
        clr <= 1;
        @(posedge core_clk);
        clr <= 0;
        repeat (W) @(posedge core_clk);
        #1;
        for (int i = 0; i < 6; i++)
        begin
            e = duty_w[i] > P + 1 ? P + 1 : duty_w[i];
            e = forced[i] ? (offl[i] ? W : 0) : e * W / (P + 1);
            cmp_pin(hi_cnt[i], e);
        end
        cmp_pin(trig_cnt, trig);
    endtask
    task end_test(input string s);
        $display("test %s done", s);
    endtask
    // hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            $display("[FAIL] %0t timeout got %h exp %h", $time, cycles, 0);
            test_done();
        end
    end
    // main sequence
    initial
    begin
        void'($urandom(32'h2aed));
        repeat (12) @(posedge core_clk);
        reset_n <= 1;
        // reset values and an unmapped address
        rdc(PWMMC_CTL0_ADDR, {24'h0, PWMMC_CTL0_RST});
        rdc(PWMMC_PERIOD_ADDR, {20'h0, PWMMC_PERIOD_RST});
        apb(0, 12'hffc, 32'h0);
        cmp_reg({31'h0, er}, 32'h1);
        end_test("reset");
        // reserved bits read back, disabled pins at off-state
        wr(PWMMC_CTL0_ADDR, 32'h14);
        rdc(PWMMC_CTL0_ADDR, 32'h14);
        wr(PWMMC_OFFLVL_ADDR, {26'h0, offl});
        repeat (3) @(posedge core_clk);
        #1;
        cmp_pin(pwm_out, offl);
        rdc(PWMMC_STATUS_ADDR, 32'h0);
        end_test("disabled");
        // holding values, then ready and enable together
        wr(PWMMC_PERIOD_ADDR, 32'(P));
        wr(PWMMC_CTL1_ADDR, 32'h0);
        wr(PWMMC_MASK_ADDR, {26'h0, mask});
        load_duty();
        wr(PWMMC_CTL0_ADDR, 32'h8b);
        wait_bit(PWMMC_STATUS_ADDR, PWMMC_STAT_CTRL_BIT, 1);
        duty_w = duty_h;
        rdc(PWMMC_CTL0_ADDR, 32'h89);
        wr(PWMMC_OFFLVL_ADDR, 32'h15);
        rdc(PWMMC_OFFLVL_ADDR, {26'h0, offl});
        measure(6'h0, W / (P + 1));
        apb(0, PWMMC_STATUS_ADDR, 32'h0);
        cmp_reg({31'h0, rd[PWMMC_STAT_DOWN_BIT]}, 32'h0);
        end_test("run");
        // new holding values wait for ready
        load_duty();
        measure(6'h0, W / (P + 1));
        wr(PWMMC_CTL0_ADDR, 32'h8b);
        wait_bit(PWMMC_CTL0_ADDR, 1, 0);
        duty_w = duty_h;
        measure(6'h0, W / (P + 1));
        end_test("reload");
        // slower timebase: divide by two, reload every second period
        wr(PWMMC_CTL1_ADDR, 32'h41);
        wr(PWMMC_CTL0_ADDR, 32'h8b);
        wait_bit(PWMMC_CTL0_ADDR, 1, 0);
        measure(6'h0, W / (2 * (P + 1)));
        end_test("prescale");
        // selective disable, trigger off
        wr(PWMMC_CTL0_ADDR, 32'hc1);
        measure(mask, 0);
        // outputs off takes effect at once
        wr(PWMMC_CTL0_ADDR, 32'h41);
        measure(6'h3f, 0);
        end_test("gating");
        // center alignment shows a down slope
        wr(PWMMC_CTL0_ADDR, 32'ha1);
        wait_bit(PWMMC_STATUS_ADDR, PWMMC_STAT_DOWN_BIT, 1);
        // disable: counter stops, pins off
        wr(PWMMC_CTL0_ADDR, 32'h0);
        measure(6'h3f, 0);
        rdc(PWMMC_STATUS_ADDR, 32'h0);
        end_test("center");
        test_done();
    end
endmodule
`default_nettype wire
